// [hw/rwf_window_timing.sv]
// Readout window, frame timing and status registers of the pixel array
`timescale 1ns/100ps
module rwf_window_timing
  import rwf_pkg::*;
#(
  parameter logic [7:0] PART_SIGNATURE   = 8'hA5,
  parameter logic [7:0] SILICON_REVISION = 8'h03
)(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // Serial control pins
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  // Statistics from neighbouring blocks
  input  wire logic [7:0]  SUBST_PIXEL_COUNT,
  input  wire logic [15:0] DARK_NOISE_SPREAD,
  input  wire logic [11:0] AUTO_EXPOSURE_LENGTH,
  // Readout timing
  output logic             FRAME_SYNC,
  output logic             LINE_VALID,
  output logic             PIXEL_VALID,
  output logic [11:0]      READ_ROW,
  output logic [11:0]      EXPOSURE_LINES
);

  rwf_core_t   c_r;
  rwf_core_t   c_nxt;
  rwf_regbus_t bus;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        ser_oe;
  logic [12:0] line_clks;
  logic [13:0] frame_rows;
  logic [13:0] win_end;
  logic [13:0] rst_ptr;
  logic        line_end;
  logic        frame_end;
  logic        win_row;
  logic        win_col;
  logic        sample_pt;

  // ==========================================================
  // Serial control port
  rwf_serial_slave u_ser (
    .clk     (MCLK),
    .rst     (RESET),
    .scl_in  (SCL_IN),
    .sda_in  (SDA_IN),
    .sda_oe  (ser_oe),
    .rd_data (rd_data),
    .rd_addr (rd_addr),
    .bus     (bus)
  );

  // ==========================================================
  // Read decode
  function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                        input rwf_core_t c);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      A_TOP_HI:   d = {4'h0, c.top[11:8]};
      A_TOP_LO:   d = c.top[7:0];
      A_LEFT_HI:  d = {4'h0, c.left[11:8]};
      A_LEFT_LO:  d = c.left[7:0];
      A_HGT_HI:   d = {4'h0, c.hgt[11:8]};
      A_HGT_LO:   d = c.hgt[7:0];
      A_WID_HI:   d = {4'h0, c.wid[11:8]};
      A_WID_LO:   d = c.wid[7:0];
      A_LGAP_HI:  d = {5'h00, c.lgap[10:8]};
      A_LGAP_LO:  d = c.lgap[7:0];
      A_SIG:      d = PART_SIGNATURE;
      A_REV:      d = SILICON_REVISION;
      A_FGAP_HI:  d = {4'h0, c.fgap[11:8]};
      A_FGAP_LO:  d = c.fgap[7:0];
      A_EXP_HI:   d = {4'h0, c.exp[11:8]};
      A_EXP_LO:   d = c.exp[7:0];
      A_EXPCTL:   d = {c.expctl[AE_EN_BIT], 7'h00};
      A_TALLY:    d = SUBST_PIXEL_COUNT;
      A_LINEIND:  d = c.out_row[11:4];
      A_NOISE_HI: d = DARK_NOISE_SPREAD[15:8];
      A_NOISE_LO: d = DARK_NOISE_SPREAD[7:0];
      A_ACTL_HI:  d = {4'h0, c.act_lines[11:8]};
      A_ACTL_LO:  d = c.act_lines[7:0];
      A_ACTP_HI:  d = {4'h0, c.act_pix[11:8]};
      A_ACTP_LO:  d = c.act_pix[7:0];
      A_PCNT_HI:  d = {3'h0, c.col[12:8]};
      A_PCNT_LO:  d = c.col[7:0];
      A_AEL_HI:   d = {4'h0, AUTO_EXPOSURE_LENGTH[11:8]};
      A_AEL_LO:   d = AUTO_EXPOSURE_LENGTH[7:0];
      A_SIG_INV:  d = ~PART_SIGNATURE;
      default:    d = 8'h00;
    endcase
    return d;
  endfunction

  assign rd_data = rd_mux(rd_addr, c_r);

  // ==========================================================
  // Row arithmetic
  // Remainder by shifted subtraction: exposure may exceed the frame
  function automatic logic [13:0] wrap_rows(input logic [25:0] v,
                                            input logic [13:0] n);
    logic [25:0] r;
    r = v;
    for (int k = 12; k >= 0; k--) begin
      if (r >= ({12'h000, n} << k)) begin
        r = r - ({12'h000, n} << k);
      end
    end
    return r[13:0];
  endfunction

  // ==========================================================
  // Next state: registers and readout timing
  always_comb begin
    c_nxt             = c_r;
    c_nxt.frame_sync  = 1'b0;
    // Register writes; status and reserved bits have no storage
    if (bus.wr) begin
      case (bus.addr)
        A_TOP_HI:  c_nxt.top[11:8]  = bus.wdata[3:0];
        A_TOP_LO:  c_nxt.top[7:0]   = bus.wdata;
        A_LEFT_HI: c_nxt.left[11:8] = bus.wdata[3:0];
        A_LEFT_LO: c_nxt.left[7:0]  = bus.wdata;
        A_HGT_HI:  c_nxt.hgt[11:8]  = bus.wdata[3:0];
        A_HGT_LO:  c_nxt.hgt[7:0]   = bus.wdata;
        A_WID_HI:  c_nxt.wid[11:8]  = bus.wdata[3:0];
        A_WID_LO:  c_nxt.wid[7:0]   = bus.wdata;
        A_LGAP_HI: c_nxt.lgap[10:8] = bus.wdata[2:0];
        A_LGAP_LO: c_nxt.lgap[7:0]  = bus.wdata;
        A_FGAP_HI: c_nxt.fgap[11:8] = bus.wdata[3:0];
        A_FGAP_LO: c_nxt.fgap[7:0]  = bus.wdata;
        A_EXP_HI:  c_nxt.exp[11:8]  = bus.wdata[3:0];
        A_EXP_LO:  c_nxt.exp[7:0]   = bus.wdata;
        A_EXPCTL:  c_nxt.expctl     = {bus.wdata[AE_EN_BIT], 7'h00};
        default:   c_nxt.expctl     = c_r.expctl;
      endcase
    end
    // Fixed array readout period plus gap, whatever the width
    line_clks  = ARRAY_LINE_CLKS + {2'b00, c_r.lgap};
    win_end    = {2'b00, c_r.top} + {2'b00, c_r.hgt};
    frame_rows = win_end + BOTTOM_DARK_LINES
                 + {2'b00, c_r.fgap};
    // At or past the end, so a gap shortened mid-line still closes it
    line_end   = (c_r.col >= line_clks - 13'h0001);
    frame_end  = line_end && (c_r.row >= frame_rows - 14'h0001);
    win_row    = (c_r.row >= {2'b00, c_r.top})
                 && (c_r.row < win_end);
    win_col    = (c_r.col < ARRAY_LINE_CLKS)
                 && (c_r.col >= {1'b0, c_r.left})
                 && (c_r.col < {1'b0, c_r.left} + {1'b0, c_r.wid});
    // Reset pointer runs the exposure length ahead of the read row
    rst_ptr     = wrap_rows({12'h000, c_r.row} + {14'h0000, c_r.eff_exp},
                            frame_rows);
    sample_pt   = (c_r.col == 13'h0000) && (rst_ptr == win_end);
    if (sample_pt) begin
      c_nxt.eff_exp = c_r.expctl[AE_EN_BIT] ?
                      AUTO_EXPOSURE_LENGTH : c_r.exp;
    end
    // Counters
    if (frame_end) begin
      c_nxt.col       = 13'h0000;
      c_nxt.row       = 14'h0000;
      c_nxt.act_lines = c_r.line_cnt;
      c_nxt.line_cnt  = 12'h000;
    end else if (line_end) begin
      c_nxt.col = 13'h0000;
      c_nxt.row = c_r.row + 14'h0001;
      if (win_row) begin
        c_nxt.line_cnt = c_r.line_cnt + 12'h001;
        c_nxt.act_pix  = c_r.pix_cnt;
      end
    end else begin
      c_nxt.col = c_r.col + 13'h0001;
    end
    if (c_r.col == 13'h0000) begin
      c_nxt.pix_cnt = 12'h000;
    end else if (c_r.pixel_valid) begin
      c_nxt.pix_cnt = c_r.pix_cnt + 12'h001;
    end
    // Registered outputs
    c_nxt.frame_sync  = (c_r.col == 13'h0000) && (c_r.row == 14'h0000);
    c_nxt.line_valid  = win_row && (c_r.col < ARRAY_LINE_CLKS);
    c_nxt.pixel_valid = win_row && win_col;
    if (win_row) begin
      c_nxt.out_row = 12'(c_r.row - {2'b00, c_r.top});
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      c_r <= '{top: TOP_RST, left: LEFT_RST, hgt: HGT_RST,
               wid: WID_RST, lgap: LGAP_RST, fgap: FGAP_RST,
               exp: EXP_RST, expctl: EXPCTL_RST, eff_exp: EXP_RST,
               default: '0};
    end else begin
      c_r <= c_nxt;
    end
  end

  // ==========================================================
  // Outputs; data line only ever pulled low
  assign SDA_OUT        = 1'b0;
  assign SDA_OE         = ser_oe;
  assign FRAME_SYNC     = c_r.frame_sync;
  assign LINE_VALID     = c_r.line_valid;
  assign PIXEL_VALID    = c_r.pixel_valid;
  assign READ_ROW       = c_r.out_row;
  assign EXPOSURE_LINES = c_r.eff_exp;

  // ==========================================================
  // Checks
  sequence s_last_col;
    line_end && !frame_end;
  endsequence

  sequence s_wrap;
    frame_end ##1 (c_r.row == 14'h0000 && c_r.col == 13'h0000);
  endsequence

  AST_RESET_WINDOW: assert property (@(posedge MCLK)
    $fell(RESET) |-> (c_r.top == 12'd12 && c_r.left == 12'd12
      && c_r.hgt == 12'd1555 && c_r.wid == 12'd2067))
    else $error("window reset values wrong");

  AST_RESET_TIMING: assert property (@(posedge MCLK)
    $fell(RESET) |-> (c_r.fgap == 12'd16 && c_r.exp == 12'd240))
    else $error("frame gap or exposure reset wrong");

  AST_RESERVED_ZERO: assert property (@(posedge MCLK)
    disable iff (RESET)
    (rd_addr == A_LGAP_HI) |-> (rd_data[7:3] == 5'h00))
    else $error("reserved bits not zero");

  AST_SIG_INVERSE: assert property (@(posedge MCLK)
    disable iff (RESET)
    (rd_addr == A_SIG_INV) |-> (rd_data == ~PART_SIGNATURE))
    else $error("signature inverse wrong");

  AST_LINE_IND: assert property (@(posedge MCLK)
    disable iff (RESET)
    (rd_addr == A_LINEIND) |-> (rd_data == READ_ROW[11:4]))
    else $error("line indicator mismatch");

  AST_WIDTH_WRITE: assert property (@(posedge MCLK)
    disable iff (RESET)
    (bus.wr && bus.addr == A_WID_HI)
      |=> (c_r.wid[11:8] == $past(bus.wdata[3:0])))
    else $error("width high byte not stored");

  AST_EXP_HOLD: assert property (@(posedge MCLK)
    disable iff (RESET)
    !sample_pt |=> $stable(EXPOSURE_LINES))
    else $error("exposure changed off the sample point");

  AST_AE_SELECT: assert property (@(posedge MCLK)
    disable iff (RESET)
    (sample_pt && c_r.expctl[AE_EN_BIT])
      |=> (EXPOSURE_LINES == $past(AUTO_EXPOSURE_LENGTH)))
    else $error("auto exposure length not taken");

  AST_FRAME_WRAP: assert property (@(posedge MCLK)
    disable iff (RESET)
    frame_end |-> s_wrap)
    else $error("frame did not wrap");

  AST_LINE_STEP: assert property (@(posedge MCLK)
    disable iff (RESET)
    s_last_col |=> (c_r.row == $past(c_r.row) + 14'h0001))
    else $error("row did not advance");

  AST_PIX_IN_LINE: assert property (@(posedge MCLK)
    disable iff (RESET)
    PIXEL_VALID |-> LINE_VALID)
    else $error("pixel outside a line");

  AST_SYNC_PULSE: assert property (@(posedge MCLK)
    disable iff (RESET)
    FRAME_SYNC |=> !FRAME_SYNC [*8])
    else $error("frame sync too long");

  AST_SYNC_ORIGIN: assert property (@(posedge MCLK)
    disable iff (RESET)
    FRAME_SYNC |-> ($past(c_r.row) == 14'h0000
      && $past(c_r.col) == 13'h0000))
    else $error("frame sync away from the frame origin");

  AST_EXP_MANUAL: assert property (@(posedge MCLK)
    disable iff (RESET)
    (sample_pt && !c_r.expctl[AE_EN_BIT])
      |=> (EXPOSURE_LINES == $past(c_r.exp)))
    else $error("programmed exposure not taken");

  AST_LGAP_WRITE: assert property (@(posedge MCLK)
    disable iff (RESET)
    (bus.wr && bus.addr == A_LGAP_HI)
      |=> (c_r.lgap[10:8] == $past(bus.wdata[2:0])))
    else $error("line gap high bits not stored");

  AST_EXPCTL_RSV: assert property (@(posedge MCLK)
    disable iff (RESET)
    (rd_addr == A_EXPCTL) |-> (rd_data[6:0] == 7'h00))
    else $error("exposure control reserved bits not zero");

  AST_STATUS_RO: assert property (@(posedge MCLK)
    disable iff (RESET)
    (bus.wr && bus.addr >= A_TALLY)
      |=> ($stable(c_r.top) && $stable(c_r.exp) && $stable(c_r.expctl)))
    else $error("status write changed a setting");

  AST_TOP_WRITE: assert property (@(posedge MCLK)
    disable iff (RESET)
    (bus.wr && bus.addr == A_TOP_LO)
      |=> (c_r.top[7:0] == $past(bus.wdata)))
    else $error("first line low byte not stored");

  AST_WIN_ROW: assert property (@(posedge MCLK)
    disable iff (RESET)
    LINE_VALID |-> ($past(c_r.row) >= {2'b00, $past(c_r.top)}))
    else $error("line output above the window");

endmodule

// [hw/rwf_pkg.sv]
// Package for the readout window and frame timing block
package rwf_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] A_TOP_HI   = 8'h00;
  localparam logic [7:0] A_TOP_LO   = 8'h01;
  localparam logic [7:0] A_LEFT_HI  = 8'h02;
  localparam logic [7:0] A_LEFT_LO  = 8'h03;
  localparam logic [7:0] A_HGT_HI   = 8'h04;
  localparam logic [7:0] A_HGT_LO   = 8'h05;
  localparam logic [7:0] A_WID_HI   = 8'h06;
  localparam logic [7:0] A_WID_LO   = 8'h07;
  localparam logic [7:0] A_LGAP_HI  = 8'h08;
  localparam logic [7:0] A_LGAP_LO  = 8'h09;
  localparam logic [7:0] A_SIG      = 8'h0A;
  localparam logic [7:0] A_REV      = 8'h0B;
  localparam logic [7:0] A_FGAP_HI  = 8'h0C;
  localparam logic [7:0] A_FGAP_LO  = 8'h0D;
  localparam logic [7:0] A_EXP_HI   = 8'h0E;
  localparam logic [7:0] A_EXP_LO   = 8'h0F;
  localparam logic [7:0] A_EXPCTL   = 8'h2F;
  localparam logic [7:0] A_TALLY    = 8'hA0;
  localparam logic [7:0] A_LINEIND  = 8'hA1;
  localparam logic [7:0] A_NOISE_HI = 8'hA2;
  localparam logic [7:0] A_NOISE_LO = 8'hA3;
  localparam logic [7:0] A_ACTL_HI  = 8'hA4;
  localparam logic [7:0] A_ACTL_LO  = 8'hA5;
  localparam logic [7:0] A_ACTP_HI  = 8'hA6;
  localparam logic [7:0] A_ACTP_LO  = 8'hA7;
  localparam logic [7:0] A_PCNT_HI  = 8'hA8;
  localparam logic [7:0] A_PCNT_LO  = 8'hA9;
  localparam logic [7:0] A_AEL_HI   = 8'hAA;
  localparam logic [7:0] A_AEL_LO   = 8'hAB;
  localparam logic [7:0] A_SIG_INV  = 8'hFF;

  // ==========================================================
  // Field positions and reset values
  localparam int          AE_EN_BIT  = 7;
  localparam logic [11:0] TOP_RST    = 12'h00C;
  localparam logic [11:0] LEFT_RST   = 12'h00C;
  localparam logic [11:0] HGT_RST    = 12'h613;
  localparam logic [11:0] WID_RST    = 12'h813;
  localparam logic [10:0] LGAP_RST   = 11'h100;
  localparam logic [11:0] FGAP_RST   = 12'h010;
  localparam logic [11:0] EXP_RST    = 12'h0F0;
  localparam logic [7:0]  EXPCTL_RST = 8'h00;

  // ==========================================================
  // Timing counts in master clocks and lines
  localparam logic [12:0] ARRAY_LINE_CLKS   = 13'h0820;
  localparam logic [13:0] BOTTOM_DARK_LINES = 14'h0008;

  // ==========================================================
  // Serial control port
  localparam logic [6:0] SER_DEV_ADDR = 7'h3C;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rwf_regbus_t;

  typedef enum logic [3:0] {
    SER_IDLE, SER_ADDR, SER_ADDR_ACK, SER_REGP, SER_REGP_ACK,
    SER_WDAT, SER_WDAT_ACK, SER_RDAT, SER_RDAT_ACK
  } rwf_ser_st_t;

  typedef struct packed {
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic        scl;
    logic        sda;
    rwf_ser_st_t st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        rnw;
    logic [7:0]  ptr;
    logic        wr;
    logic [7:0]  wdata;
    logic [7:0]  waddr;
    logic        sda_oe;
  } rwf_ser_t;

  typedef struct packed {
    logic [11:0] top;
    logic [11:0] left;
    logic [11:0] hgt;
    logic [11:0] wid;
    logic [10:0] lgap;
    logic [11:0] fgap;
    logic [11:0] exp;
    logic [7:0]  expctl;
    logic [12:0] col;
    logic [13:0] row;
    logic [11:0] eff_exp;
    logic [11:0] line_cnt;
    logic [11:0] act_lines;
    logic [11:0] pix_cnt;
    logic [11:0] act_pix;
    logic        frame_sync;
    logic        line_valid;
    logic        pixel_valid;
    logic [11:0] out_row;
  } rwf_core_t;

endpackage

// [hw/rwf_serial_slave.sv]
// Two-wire serial control slave giving byte access to the registers
`timescale 1ns/100ps
module rwf_serial_slave
  import rwf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_oe,
  // Register side
  input  wire logic [7:0]  rd_data,
  output logic [7:0]       rd_addr,
  output rwf_regbus_t      bus
);

  rwf_ser_t s_r;
  rwf_ser_t s_nxt;
  logic     scl_rise;
  logic     scl_fall;
  logic     start_c;
  logic     stop_c;

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt        = s_r;
    s_nxt.wr     = 1'b0;
    s_nxt.scl_sy = {s_r.scl_sy[1:0], scl_in};
    s_nxt.sda_sy = {s_r.sda_sy[1:0], sda_in};
    // Filtered levels: a change counts once stages two and three agree
    if (s_r.scl_sy[1] == s_r.scl_sy[2]) begin
      s_nxt.scl = s_r.scl_sy[2];
    end
    if (s_r.sda_sy[1] == s_r.sda_sy[2]) begin
      s_nxt.sda = s_r.sda_sy[2];
    end
    scl_rise = s_nxt.scl & ~s_r.scl;
    scl_fall = ~s_nxt.scl & s_r.scl;
    start_c  = s_r.scl & s_nxt.scl & s_r.sda & ~s_nxt.sda;
    stop_c   = s_r.scl & s_nxt.scl & ~s_r.sda & s_nxt.sda;
    if (start_c) begin
      s_nxt.st     = SER_ADDR;
      s_nxt.cnt    = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_nxt.st     = SER_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      case (s_r.st)
        SER_ADDR, SER_REGP, SER_WDAT: begin
          if (scl_rise) begin
            s_nxt.sh  = {s_r.sh[6:0], s_nxt.sda};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall && s_r.cnt == 4'h8) begin
            s_nxt.cnt    = 4'h0;
            s_nxt.sda_oe = 1'b1;
            if (s_r.st == SER_ADDR) begin
              s_nxt.rnw = s_r.sh[0];
              if (s_r.sh[7:1] == SER_DEV_ADDR) begin
                s_nxt.st = SER_ADDR_ACK;
              end else begin
                s_nxt.st     = SER_IDLE;
                s_nxt.sda_oe = 1'b0;
              end
            end else if (s_r.st == SER_REGP) begin
              s_nxt.ptr = s_r.sh;
              s_nxt.st  = SER_REGP_ACK;
            end else begin
              s_nxt.wr    = 1'b1;
              s_nxt.waddr = s_r.ptr;
              s_nxt.wdata = s_r.sh;
              s_nxt.ptr   = s_r.ptr + 8'h01;
              s_nxt.st    = SER_WDAT_ACK;
            end
          end
        end
        SER_ADDR_ACK, SER_RDAT_ACK: begin
          // Master NACK on a read ends the transfer
          if (s_r.st == SER_RDAT_ACK && scl_rise && s_nxt.sda) begin
            s_nxt.st = SER_IDLE;
          end else if (scl_fall) begin
            if (s_r.st == SER_ADDR_ACK && !s_r.rnw) begin
              s_nxt.st     = SER_REGP;
              s_nxt.sda_oe = 1'b0;
            end else begin
              s_nxt.sh     = rd_data;
              s_nxt.sda_oe = ~rd_data[7];
              s_nxt.ptr    = s_r.ptr + 8'h01;
              s_nxt.cnt    = 4'h0;
              s_nxt.st     = SER_RDAT;
            end
          end
        end
        SER_REGP_ACK, SER_WDAT_ACK: begin
          if (scl_fall) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.st     = SER_WDAT;
          end
        end
        SER_RDAT: begin
          if (scl_fall) begin
            if (s_r.cnt == 4'h7) begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.st     = SER_RDAT_ACK;
            end else begin
              s_nxt.sh     = {s_r.sh[6:0], 1'b0};
              s_nxt.sda_oe = ~s_r.sh[6];
              s_nxt.cnt    = s_r.cnt + 4'h1;
            end
          end
        end
        default: begin
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{scl_sy: 3'h7, sda_sy: 3'h7, scl: 1'b1, sda: 1'b1,
               st: SER_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_oe    = s_r.sda_oe;
  assign rd_addr   = s_r.ptr;
  assign bus.wr    = s_r.wr;
  assign bus.addr  = s_r.waddr;
  assign bus.wdata = s_r.wdata;

endmodule

// [testbench/rwf_host_model.sv]
// Host model driving the two-wire serial control port
`timescale 1ns/100ps
module rwf_host_model
  import rwf_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Serial wire
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic       pull_low;
  logic [7:0] ptr;
  logic       ptr_ok;
  int         misses;
  // ==========================================================
  // Open drain wire, pull-up when nobody pulls low
  assign sda = ~(pull_low | sda_oe);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
    ptr_ok = 1'b0;
    misses = 0;
  end
  // ==========================================================
  // Bus phases, 9 clocks each to clear the pin filters
  task automatic ph(input logic c, input logic d);
    @(posedge clk);
    scl <= c;
    pull_low <= ~d;
    repeat (8) @(posedge clk);
  endtask
  task automatic start;
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask
  task automatic stop;
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // Data only moves while the clock is low, never beside an edge
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      ph(1'b0, d[i]);
      ph(1'b1, d[i]);
      q[i] = sda;
      ph(1'b0, d[i]);
    end
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ack = ~sda;
    ph(1'b0, 1'b1);
  endtask
  task automatic put(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    xfer(d, q, a);
    if (a !== 1'b1) misses++;
  endtask
  // ==========================================================
  // Register access; pointer reuse saves a whole transfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    start();
    put({SER_DEV_ADDR, 1'b0});
    put(a);
    foreach (d[i]) put(d[i]);
    stop();
    ptr = a + 8'(d.size());
    ptr_ok = 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic n;
    if (!(ptr_ok && ptr == a)) begin
      start();
      put({SER_DEV_ADDR, 1'b0});
      put(a);
      stop();
    end
    start();
    put({SER_DEV_ADDR, 1'b1});
    xfer(8'hFF, q, n);
    stop();
    ptr = a + 8'h01;
    ptr_ok = 1'b1;
  endtask
endmodule

// [testbench/readout_window_frame_timing_tb.sv]
// Self-checking bench for the readout window and frame timing block
`timescale 1ns/100ps
module readout_window_frame_timing_tb
  import rwf_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [7:0] v;} rwf_row_t;
  localparam logic [7:0] SIG = 8'h5C; // Arbitrary signature
  localparam logic [7:0] REV = 8'h02; // Arbitrary revision
  logic        mclk, reset, scl, sda, sda_oe, fs, lv, pv, lv_q;
  logic [11:0] rrow, expl;
  logic [7:0]  q;
  int          bad_count, total_checks, cyc, pv_run, t0;
  rwf_row_t rows [22] = '{'{8'h00,8'h00}, '{8'h01,8'h0C}, '{8'h02,8'h00},
    '{8'h03,8'h0C}, '{8'h04,8'h06}, '{8'h05,8'h13}, '{8'h06,8'h08},
    '{8'h07,8'h13}, '{8'h08,8'h01}, '{8'h09,8'h00}, '{8'h0A,SIG},
    '{8'h0B,REV}, '{8'h0C,8'h00}, '{8'h0D,8'h10}, '{8'h0E,8'h00},
    '{8'h0F,8'hF0}, '{8'h2F,8'h00}, '{8'hA0,8'h3C}, '{8'hA2,8'h9B},
    '{8'hA3,8'h7E}, '{8'hAA,8'h03}, '{8'hFF,~SIG}};
  // ==========================================================
  // Design and host
  rwf_window_timing #(.PART_SIGNATURE(SIG), .SILICON_REVISION(REV))
    rwf_window_timing_inst (.MCLK(mclk), .RESET(reset), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
    .SUBST_PIXEL_COUNT(8'h3C), .DARK_NOISE_SPREAD(16'h9B7E),
    .AUTO_EXPOSURE_LENGTH(12'h321), .FRAME_SYNC(fs), .LINE_VALID(lv),
    .PIXEL_VALID(pv), .READ_ROW(rrow), .EXPOSURE_LINES(expl));
  rwf_host_model rwf_host_model_inst (.clk(mclk), .sda_oe(sda_oe),
    .scl(scl), .sda(sda));
  // ==========================================================
  // Clock, cycle count and pixel count per line
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    lv_q <= lv;
    pv_run <= (lv === 1'b1 && lv_q === 1'b0) ? 0 : pv_run + int'(pv);
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic do_reset;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic lv_rise;
    @(posedge mclk iff (lv === 1'b1 && lv_q === 1'b0));
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    lv_q = 1'b0;
    cyc = 0;
    pv_run = 0;
    bad_count = 0;
    total_checks = 0;
    do_reset();
    foreach (rows[i]) begin
      rwf_host_model_inst.rd(rows[i].a, q);
      check(q, rows[i].v);
    end
    rwf_host_model_inst.wr(8'h02, {8'hFF});
    rwf_host_model_inst.rd(8'h02, q);
    check(q, 8'h0F);
    rwf_host_model_inst.wr(8'h0A, {8'h00});
    rwf_host_model_inst.rd(8'h0A, q);
    check(q, SIG);
    rwf_host_model_inst.wr(8'hA0, {8'h00});
    rwf_host_model_inst.rd(8'hA0, q);
    check(q, 8'h3C);
    // Second reset restarts the frame at row 0, so a short frame fits
    do_reset();
    check(expl, 12'h0F0);
    // Top 0, height 2, width 8, short gaps: 18 lines of 2088 clocks
    rwf_host_model_inst.wr(8'h00, {8'h00, 8'h00, 8'h00, 8'h0C, 8'h00,
      8'h02, 8'h00, 8'h08, 8'h00, 8'h08});
    rwf_host_model_inst.wr(8'h0C,
      {8'h00, 8'h08, 8'h00, 8'h05});
    @(posedge mclk iff fs === 1'b1);
    check(expl, 12'h005);
    t0 = cyc;
    // Row 0 opens with the sync pulse, so the next rise is row 1
    lv_rise();
    check(cyc - t0, 2088);
    check(pv_run, 8);
    check(rrow, 12'h001);
    rwf_host_model_inst.wr(8'h2F, {8'h80});
    @(posedge mclk iff fs === 1'b1);
    check(cyc - t0, 18 * 2088);
    check(expl, 12'h321);
    check(rwf_host_model_inst.misses, 0);
    close_out();
  end
  initial begin
    repeat (120000) @(posedge mclk);
    bad_count++;
    close_out();
  end
endmodule
